/* rtl/pixfmt_consts.vh */
// Constants for the YCbCr parallel output formatter: offsets, fields, resets, code limits
`ifndef PIXFMT_CONSTS_VH
`define PIXFMT_CONSTS_VH

// Register byte offsets on the APB
`define CTRL_OFFSET       12'h000
`define STATUS_OFFSET     12'h004
`define LINES_OFFSET      12'h008

// Control field positions
`define CTRL_MODE_LSB     0
`define CTRL_MODE_MSB     1
`define CTRL_CHROMA_SWAP  2
`define CTRL_LUMA_FIRST   3
`define CTRL_MSB_ALIGN    4
`define CTRL_ENABLE       5
`define CTRL_WIDTH        6
`define CTRL_RESET        6'h00

// Output mode codes
`define MODE_BYTE         2'h0
`define MODE_TEN          2'h1
`define MODE_WIDE         2'h2

// Legal code ranges, 8-bit and 10-bit spaces
`define LUMA8_MIN         10'h010
`define LUMA8_MAX         10'h0EB
`define CHROMA8_MIN       10'h010
`define CHROMA8_MAX       10'h0F0
`define LUMA10_MIN        10'h040
`define LUMA10_MAX        10'h3AC
`define CHROMA10_MIN      10'h040
`define CHROMA10_MAX      10'h3C0

`endif

/* rtl/code_range_clamp.v */
// Clamps one video component into its legal code range
`timescale 1ns/1ps
module code_range_clamp (
  // Sample in, already reduced to the selected code space
  input  wire [9:0] value_in,
  // Selects 10-bit limits instead of 8-bit limits
  input  wire       ten_bit,
  // Selects luma limits instead of chroma limits
  input  wire       is_luma,
  // Clamped sample
  output reg  [9:0] value_out
);
`include "pixfmt_consts.vh"

  reg [9:0] lo;  // Lower limit in use
  reg [9:0] hi;  // Upper limit in use

  // Pick the limits, then saturate
  always @*
  begin
    lo = ten_bit ? (is_luma ? `LUMA10_MIN : `CHROMA10_MIN) : (is_luma ? `LUMA8_MIN : `CHROMA8_MIN);
    hi = ten_bit ? (is_luma ? `LUMA10_MAX : `CHROMA10_MAX) : (is_luma ? `LUMA8_MAX : `CHROMA8_MAX);
    if (value_in < lo)
      value_out = lo;
    else if (value_in > hi)
      value_out = hi;
    else
      value_out = value_in;
  end
endmodule // code_range_clamp

/* rtl/ycbcr_parallel_output_formatter.v */
// Formats 4:2:2 YCbCr pixel pairs onto a 16-bit parallel output bus
`timescale 1ns/1ps
module ycbcr_parallel_output_formatter #(
  parameter CW = 10  // Component width at the pixel input
) (
  // Clock, reset, clock enable
  input  wire          clk,
  input  wire          rst,
  input  wire          ce,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // Pixel pair stream in
  input  wire          in_valid,
  output reg           in_ready,
  input  wire [CW-1:0] in_y0,
  input  wire [CW-1:0] in_y1,
  input  wire [CW-1:0] in_cb,
  input  wire [CW-1:0] in_cr,
  input  wire          in_line_end,
  input  wire          in_frame_end,
  // Parallel output link
  input  wire          pclk_in,
  output reg           pout_clk,
  output reg  [15:0]   pout_data,
  output reg           pout_line_valid,
  output reg           pout_frame_valid
);
`include "pixfmt_consts.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  reg [`CTRL_WIDTH-1:0] ctrl_reg;       // Software control word
  reg [`CTRL_WIDTH-1:0] cfg_reg;        // Control captured with the held pair
  reg [15:0]            lines_reg;      // Lines finished in this frame
  reg                   pclk_s1_reg;    // Link clock synchroniser, first stage
  reg                   pclk_s2_reg;    // Link clock synchroniser, second stage
  reg                   pclk_s3_reg;    // Delayed copy for edge finding
  reg [9:0]             y0_reg;         // Held pair components
  reg [9:0]             y1_reg;
  reg [9:0]             cb_reg;
  reg [9:0]             cr_reg;
  reg                   line_end_reg;   // Held pair closes a line
  reg                   frame_end_reg;  // Held pair closes a frame
  reg                   full_reg;       // A pair is held
  reg [1:0]             widx_reg;       // Word index inside the pair
  reg                   gap_reg;        // Blank word owed after a line end
  reg                   fgap_reg;       // Frame valid drop owed after frame end
  reg                   full_next;      // Held flag after this edge

  wire       fall_evt  = pclk_s3_reg & ~pclk_s2_reg;  // Data moves on the falling link edge
  wire       accept    = ce & in_valid & in_ready;
  wire       apb_acc   = psel & penable & ~pready;
  wire [1:0] mode      = cfg_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire       wide      = (mode == `MODE_WIDE);
  wire       ten       = (mode == `MODE_TEN);
  wire       last_word = wide ? widx_reg[0] : (widx_reg == 2'h3);

  ////////////////////////////////////////////////////////////////////////////
  // Component selection for the current word

  // Reduce to the 8-bit space where the mode asks for it
  function [9:0] to_space;
    input [9:0] v;
    input       t;
    begin
      to_space = t ? v : {2'h0, v[9:2]};
    end
  endfunction

  // Keep the top ten bits of a component; narrower inputs are padded with zeros
  function [9:0] top_ten;
    input [CW+9:0] v;
    begin
      top_ten = v[CW+9 -: 10];
    end
  endfunction

  wire       half   = wide ? widx_reg[0] : widx_reg[1];       // Which pixel of the pair
  wire [9:0] c_frst = cfg_reg[`CTRL_CHROMA_SWAP] ? cr_reg : cb_reg;
  wire [9:0] c_scnd = cfg_reg[`CTRL_CHROMA_SWAP] ? cb_reg : cr_reg;
  wire [9:0] c_raw  = half ? c_scnd : c_frst;
  wire [9:0] y_raw  = half ? y1_reg : y0_reg;
  wire [9:0] c_lim;
  wire [9:0] y_lim;

  code_range_clamp chroma_clamp (
    .value_in  (to_space(c_raw, ten)),
    .ten_bit   (ten),
    .is_luma   (1'b0),
    .value_out (c_lim)
  );

  code_range_clamp luma_clamp (
    .value_in  (to_space(y_raw, ten)),
    .ten_bit   (ten),
    .is_luma   (1'b1),
    .value_out (y_lim)
  );

  reg [9:0]  comp;   // Component for a single-component word (byte and ten-bit modes)
  reg [15:0] word;   // Placed bus word

  // Build the bus word from mode, order and alignment
  always @*
  begin
    comp = (widx_reg[0] ^ cfg_reg[`CTRL_LUMA_FIRST]) ? y_lim : c_lim;
    if (wide)
      // Both alignments give the full bus here
      word = cfg_reg[`CTRL_LUMA_FIRST] ? {y_lim[7:0], c_lim[7:0]} : {c_lim[7:0], y_lim[7:0]};
    else if (ten)
      word = cfg_reg[`CTRL_MSB_ALIGN] ? {comp, 6'h00} : {6'h00, comp};
    else
      word = cfg_reg[`CTRL_MSB_ALIGN] ? {comp[7:0], 8'h00} : {8'h00, comp[7:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link clock sampling; only the second and third stages feed logic

  always @(posedge clk)
  begin
    if (rst)
    begin
      pclk_s1_reg <= 1'b0;
      pclk_s2_reg <= 1'b0;
      pclk_s3_reg <= 1'b0;
      pout_clk    <= 1'b0;
    end
    else if (ce)
    begin
      pclk_s1_reg <= pclk_in;
      pclk_s2_reg <= pclk_s1_reg;
      pclk_s3_reg <= pclk_s2_reg;
      pout_clk    <= pclk_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Held flag after this edge, so ready can be a flip-flop

  always @*
  begin
    full_next = full_reg;
    if (fall_evt & full_reg & ~gap_reg & ~fgap_reg & last_word)
      full_next = 1'b0;
    if (accept)
      full_next = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pair capture and word sequencing

  always @(posedge clk)
  begin
    if (rst)
    begin
      y0_reg           <= 10'h000;
      y1_reg           <= 10'h000;
      cb_reg           <= 10'h000;
      cr_reg           <= 10'h000;
      line_end_reg     <= 1'b0;
      frame_end_reg    <= 1'b0;
      cfg_reg          <= `CTRL_RESET;
      full_reg         <= 1'b0;
      widx_reg         <= 2'h0;
      gap_reg          <= 1'b0;
      fgap_reg         <= 1'b0;
      in_ready         <= 1'b0;
      lines_reg        <= 16'h0000;
      pout_data        <= 16'h0000;
      pout_line_valid  <= 1'b0;
      pout_frame_valid <= 1'b0;
    end
    else if (ce)
    begin
      full_reg <= full_next;
      // Ready only while nothing is held and software enables the path
      in_ready <= ~full_next & ctrl_reg[`CTRL_ENABLE];
      // Capture a new pair with the control in force at that moment
      if (accept)
      begin
        y0_reg        <= top_ten({in_y0, 10'h000});
        y1_reg        <= top_ten({in_y1, 10'h000});
        cb_reg        <= top_ten({in_cb, 10'h000});
        cr_reg        <= top_ten({in_cr, 10'h000});
        line_end_reg  <= in_line_end;
        frame_end_reg <= in_frame_end;
        cfg_reg       <= ctrl_reg;
      end
      if (fall_evt)
      begin
        if (fgap_reg)
        begin
          // Frame closes: both qualifiers low for one link period
          pout_line_valid  <= 1'b0;
          pout_frame_valid <= 1'b0;
          pout_data        <= 16'h0000;
          fgap_reg         <= 1'b0;
        end
        else if (gap_reg | ~full_reg)
        begin
          // Horizontal blank or starved source
          pout_line_valid <= 1'b0;
          pout_data       <= 16'h0000;
          gap_reg         <= 1'b0;
        end
        else
        begin
          pout_data        <= word;
          pout_line_valid  <= 1'b1;
          pout_frame_valid <= 1'b1;
          if (~pout_frame_valid)
            lines_reg <= 16'h0000;
          if (last_word)
          begin
            widx_reg <= 2'h0;
            gap_reg  <= line_end_reg;
            fgap_reg <= frame_end_reg;
            if (line_end_reg)
              lines_reg <= (pout_frame_valid ? lines_reg : 16'h0000) + 16'h0001;
          end
          else
            widx_reg <= widx_reg + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, error on unmapped address

  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_reg <= `CTRL_RESET;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= apb_acc;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      // Commit a write only at the edge that completes the access, as the master sees it
      if (psel & penable & pready & pwrite & (paddr == `CTRL_OFFSET))
        ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
      if (apb_acc)
      begin
        case (paddr)
          `CTRL_OFFSET:
            prdata <= {26'h000_0000, ctrl_reg};
          `STATUS_OFFSET:
            prdata <= {26'h000_0000, full_reg, widx_reg, pout_frame_valid, pout_line_valid, in_ready};
          `LINES_OFFSET:
            prdata <= {16'h0000, lines_reg};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // ycbcr_parallel_output_formatter

/* tb/pixfmt_monitor.sv */
// Port checker for the YCbCr parallel output formatter
`timescale 1ns/1ps
module pixfmt_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // APB answer
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pair handshake
  input wire logic        in_valid,
  input wire logic        in_ready,
  // Link
  input wire logic        pclk_in,
  input wire logic        pout_clk,
  input wire logic [15:0] pout_data,
  input wire logic        pout_line_valid,
  input wire logic        pout_frame_valid
);
  // One domain, so one clock and one disable for all
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////
  // Access phase always takes one wait cycle
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  // Ready is a single-cycle pulse
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  // Error only ends an access
  err_ready_a: assert property (pslverr |-> pready)
    else $error("stray error");
  // An accepted pair blocks the next one
  accept_drop_a: assert property (in_valid && in_ready |=> !in_ready)
    else $error("ready after accept");
  // Forwarded clock lags three cycles; reset history is skipped
  clk_follow_a: assert property (!$past(rst, 5) |-> pout_clk == $past(pclk_in, 3))
    else $error("pixel clock skew");
  // Clamped codes are never zero on an active word
  code_nonzero_a: assert property (pout_line_valid |-> pout_data != 16'h0000)
    else $error("zero code");
  // Line qualifier only inside a frame
  line_in_frame_a: assert property (pout_line_valid |-> pout_frame_valid)
    else $error("line outside frame");
  // A frame opens on an active word
  frame_start_a: assert property ($rose(pout_frame_valid) |-> pout_line_valid)
    else $error("frame opens blank");
endmodule // pixfmt_monitor

bind ycbcr_parallel_output_formatter pixfmt_monitor pixfmt_monitor_inst (.clk, .rst, .psel, .penable,
  .pready, .pslverr, .in_valid, .in_ready, .pclk_in, .pout_clk, .pout_data, .pout_line_valid,
  .pout_frame_valid);

/* tb/pix_receiver.sv */
// Receiver model that captures active words from the parallel link
`timescale 1ns/1ps
module pix_receiver (
  // Link from the formatter
  input wire logic        pout_clk,
  input wire logic [15:0] pout_data,
  input wire logic        pout_line_valid,
  input wire logic        pout_frame_valid
);
  logic [15:0] words [$];  // Captured words, oldest first
  // Sample on the rising pixel clock, in arrival order, qualifiers only
  always @(posedge pout_clk)
  begin
    if (pout_line_valid && pout_frame_valid)
      words.push_back(pout_data);
  end
endmodule // pix_receiver

/* tb/tb_ycbcr_parallel_output_formatter.sv */
// Self-checking bench for the YCbCr parallel output formatter
`timescale 1ns/1ps
module tb_ycbcr_parallel_output_formatter;
  logic        clk = 0, rst = 1, ce = 1;  // Ce stays high: stalls untested
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic        in_valid = 0, in_ready, in_line_end = 0, in_frame_end = 0;
  logic [9:0]  in_y0 = '0, in_y1 = '0, in_cb = '0, in_cr = '0;
  logic        pclk_in = 0, pout_clk, pout_line_valid, pout_frame_valid;
  logic [15:0] pout_data;
  logic [15:0] exp_q [$];  // Words the link should carry
  int          n_tests = 0, n_fail = 0, cyc = 0, k;
  ycbcr_parallel_output_formatter ycbcr_parallel_output_formatter_inst (.clk, .rst, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_ready, .in_y0,
    .in_y1, .in_cb, .in_cr, .in_line_end, .in_frame_end, .pclk_in, .pout_clk, .pout_data,
    .pout_line_valid, .pout_frame_valid);
  pix_receiver pix_receiver_inst (.pout_clk, .pout_data, .pout_line_valid, .pout_frame_valid);
  ////////////////////////
  // Clocks; link runs at one eighth of clk, phase offset keeps their edges apart
  always #10 clk = ~clk;
  initial
  begin
    #3;
    forever #80 pclk_in = ~pclk_in;
  end
  // Hang guard: the run needs a few thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  ////////////////////////
  task report_and_stop;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] x, input string m);
    n_tests++;
    if (g !== x)
    begin
      n_fail++;
      $display("BAD %0t %s got %h want %h", $time, m, g, x);
    end
  endtask
  // APB transfer: setup, then access held until ready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Code-space reduction and legal-range clamp
  function automatic logic [9:0] lim(logic [9:0] v, logic t, logic y);
    logic [9:0] x, lo, hi;
    x = t ? v : {2'b00, v[9:2]};
    lo = t ? 10'h040 : 10'h010;
    hi = t ? (y ? 10'h3ac : 10'h3c0) : (y ? 10'h0eb : 10'h0f0);
    return (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction
  // Queue the words one pair must produce under control c
  function automatic void expect_pair(logic [5:0] c, logic [9:0] v [4]);
    logic [9:0] s [4];
    logic       t;
    t = c[1:0] == 2'h1;
    if (c[3])
      s = '{lim(v[0], t, 1), lim(v[c[2] ? 3 : 2], t, 0), lim(v[1], t, 1), lim(v[c[2] ? 2 : 3], t, 0)};
    else
      s = '{lim(v[c[2] ? 3 : 2], t, 0), lim(v[0], t, 1), lim(v[c[2] ? 2 : 3], t, 0), lim(v[1], t, 1)};
    if (c[1:0] == 2'h2)
    begin
      exp_q.push_back({s[0][7:0], s[1][7:0]});
      exp_q.push_back({s[2][7:0], s[3][7:0]});
    end
    else
      foreach (s[i]) exp_q.push_back(c[4] ? (t ? {s[i], 6'h00} : {s[i][7:0], 8'h00}) : {6'h00, s[i]});
  endfunction
  // Offer one random pair; corner pair forces both clamp ends
  task send_pair(input logic [5:0] c, input logic corner);
    logic [9:0] v [4];
    foreach (v[i]) v[i] = corner ? (i == 0 ? 10'h000 : 10'h3ff) : 10'($urandom);
    expect_pair(c, v);
    @(posedge clk);
    in_valid <= 1;
    {in_y0, in_y1, in_cb, in_cr} <= {v[0], v[1], v[2], v[3]};
    {in_line_end, in_frame_end} <= 2'($urandom);
    do @(posedge clk); while (in_ready !== 1'b1);
    in_valid <= 0;
  endtask
  ////////////////////////
  // Every mode, swap and alignment combination in turn
  initial
  begin
    k = $urandom(45718);
    repeat (20) @(posedge clk);
    rst <= 0;
    apb(0, 12'h000, 32'h0000_0000);
    chk(q[15:0], 16'h0000, "ctrl reset");
    chk({15'h0000, in_ready}, 16'h0000, "ready while off");
    apb(0, 12'h00c, 32'h0000_0000);
    chk({q[14:0], e}, 16'h0001, "unmapped");
    for (int c = 0; c < 32; c++)
    begin
      apb(1, 12'h000, {26'h0, 1'b1, 5'(c)});
      apb(0, 12'h000, 32'h0000_0000);
      chk(q[15:0], {10'h000, 1'b1, 5'(c)}, "ctrl readback");
      send_pair({1'b1, 5'(c)}, 1);
      send_pair({1'b1, 5'(c)}, 0);
      k = 0;
      while (pix_receiver_inst.words.size() < exp_q.size() && k++ < 400) @(posedge clk);
      chk(16'(pix_receiver_inst.words.size()), 16'(exp_q.size()), "word count");
      foreach (exp_q[i]) chk(pix_receiver_inst.words[i], exp_q[i], "word");
      pix_receiver_inst.words.delete();
      exp_q.delete();
    end
    report_and_stop;
  end
endmodule // tb_ycbcr_parallel_output_formatter
